// ---- core/arpg_regs.vh ----
/*
 * Register indices, field widths, reset values and bus answers of the
 * analog-shared port and port R pin controller.
 * Assumes byte address = 4 * index on a 12-bit AXI4-Lite address.
 */
`ifndef ARPG_REGS_VH
`define ARPG_REGS_VH

// Address width of the register bus
`define ARPG_AW            12
// Decoded index range of the port block; holes read zero
`define ARPG_IDX_FIRST     10'h0270
`define ARPG_IDX_LAST      10'h028F

// Register indices (byte address is four times the index)
`define ARPG_IDX_AD_DATA   10'h0271
`define ARPG_IDX_AD_DIR    10'h0273
`define ARPG_IDX_AD_PE_LO  10'h0276
`define ARPG_IDX_AD_PE_HI  10'h0277
`define ARPG_IDX_AD_PS_LO  10'h0278
`define ARPG_IDX_AD_PS_HI  10'h0279
`define ARPG_IDX_R_DATA    10'h0280
`define ARPG_IDX_R_DIR     10'h0282

// Port widths
`define ARPG_W_HI          8
`define ARPG_W_LO          4

// Reset values
`define ARPG_RST_8         8'h00
`define ARPG_RST_4         4'h0

// AXI4-Lite response codes
`define ARPG_RESP_OKAY     2'b00
`define ARPG_RESP_DECERR   2'b11

// Depth of the pin input synchronisers, in bus clock cycles
`define ARPG_SYNC_STAGES   2

`endif

// ---- core/arpg_sync_sel.v ----
/*
 * Per-bit input synchroniser and data read select for one GPIO port.
 * Assumes pin inputs arrive asynchronously; clk is the bus clock.
 */
`timescale 1ns/100ps
module arpg_sync_sel #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         ce,
    input  wire [W-1:0] pin_in,
    input  wire [W-1:0] in_en,
    input  wire [W-1:0] dir,
    input  wire [W-1:0] data,
    output wire [W-1:0] level,
    output wire [W-1:0] rd_val
);

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_r;   // First stage, read only by second stage
            reg sync_r;   // Settled pin level

            // Two-stage synchroniser, frozen while ce is low
            always @(posedge clk) begin
                if (rst) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else if (ce) begin
                    meta_r <= pin_in[i];
                    sync_r <= meta_r;
                end
            end

            // Input buffer gated by its digital enable
            assign level[i]  = sync_r & in_en[i];
            // Output: stored bit; input: pin level
            assign rd_val[i] = dir[i] ? data[i] : level[i];
        end
    endgenerate

endmodule // arpg_sync_sel

// ---- core/arpg_top.v ----
/*
 * Analog-shared port and port R GPIO controller with an AXI4-Lite
 * register slave, pull control and port R alternate function routing.
 * Assumes the peripherals hand in their enables and output levels
 * synchronous to clk, and that the pad drives the pin from out/oe.
 */
// Our own choice: register access over AXI4-Lite.
// Function
// - Analog direction bit one makes pin output
// - Data reads lag pin change two cycles
// - Reserved locations read zero, ignore writes
// - Pull-enable bit one turns pull on
// - Output pins ignore their pull-enable bit
// - Polarity register picks pull up or down
// - GPIO output pins drive data register bit
// - Read returns data bit or synced pin
// - LCD overrides GPIO and I2C, pins 7-4
// - I2C owns pins six, five without LCD
// - Second timer compare overrides GPIO, pins 3-2
// - CAN over timer over GPIO, pins 1-0
`timescale 1ns/100ps
`include "arpg_regs.vh"
module arpg_top (
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    // AXI4-Lite slave
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Analog-shared port, high eight pins
    input  wire [7:0]  ad_hi_pin_in,
    output reg  [7:0]  ad_hi_pin_out,
    output reg  [7:0]  ad_hi_pin_oe,
    output reg  [7:0]  ad_hi_pull_en,
    output reg  [7:0]  ad_hi_pull_up,
    input  wire [7:0]  converter_digital_input_enable,
    // Analog-shared port, low four pins (direction held elsewhere)
    input  wire [3:0]  ad_lo_dir,
    output reg  [3:0]  ad_lo_pull_en,
    output reg  [3:0]  ad_lo_pull_up,
    // Port R pins
    input  wire [7:0]  r_pin_in,
    output reg  [7:0]  r_pin_out,
    output reg  [7:0]  r_pin_oe,
    output wire [7:0]  r_pin_level,
    // Peripheral requests for port R
    input  wire [3:0]  lcd_seg_en,
    input  wire        i2c_en,
    input  wire        i2c_scl_drive_low,
    input  wire        i2c_sda_drive_low,
    input  wire [1:0]  tmr_b_oc_en,
    input  wire [1:0]  tmr_b_oc_out,
    input  wire [1:0]  tmr_a_oc_en,
    input  wire [1:0]  tmr_a_oc_out,
    input  wire        can_en,
    input  wire        can_transmit_pin,
    output wire        can_receive_pin,
    output reg  [3:0]  r_lcd_sel
);

    // Software-visible registers
    reg  [7:0]  analog_port_direction_high_r;    // 1 = output
    reg  [7:0]  analog_port_data_high_r;         // Output data
    reg  [3:0]  analog_port_pull_enable_low_r;   // Pull enables
    reg  [7:0]  analog_port_pull_enable_high_r;  // Pull enables
    reg  [3:0]  ad_pol_lo_r;                     // 0 = up, 1 = down
    reg  [7:0]  ad_pol_hi_r;                     // 0 = up, 1 = down
    reg  [7:0]  port_r_pin_data_r;               // Output data
    reg  [7:0]  port_r_direction_r;              // 1 = output

    // Write channel holding state
    reg  [9:0]  aw_idx_r;       // Captured write index
    reg         aw_full_r;      // Address held
    reg  [7:0]  w_byte_r;       // Captured low data byte
    reg         w_lane_r;       // Low byte lane strobe
    reg         w_full_r;       // Data held

    // Read side results from the synchronisers
    wire [7:0]  ad_rd;          // Analog data read value
    wire [7:0]  ad_level;       // Analog synced pin level
    wire [7:0]  r_rd;           // Port R data read value

    // Decode helpers
    wire [9:0]  ar_idx;         // Read index
    wire        ar_in_range;    // Read hits the port block
    wire        aw_in_range;    // Held write hits the port block
    wire        do_write;       // Commit the held write
    reg  [7:0]  rd_byte;        // Selected read byte

    // Handshake readies: single outstanding transfer each way
    assign s_axi_awready = ce & ~aw_full_r & ~s_axi_bvalid;
    assign s_axi_wready  = ce & ~w_full_r & ~s_axi_bvalid;
    assign s_axi_arready = ce & ~s_axi_rvalid;

    assign ar_idx      = s_axi_araddr[11:2];
    assign ar_in_range = (ar_idx >= `ARPG_IDX_FIRST) &&
                         (ar_idx <= `ARPG_IDX_LAST);
    assign aw_in_range = (aw_idx_r >= `ARPG_IDX_FIRST) &&
                         (aw_idx_r <= `ARPG_IDX_LAST);
    assign do_write    = ce & aw_full_r & w_full_r & ~s_axi_bvalid;

    // Analog port input synchronisers and read select
    arpg_sync_sel #(
        .W      (8)
    ) u_ad_sync (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .pin_in (ad_hi_pin_in),
        .in_en  (converter_digital_input_enable),
        .dir    (analog_port_direction_high_r),
        .data   (analog_port_data_high_r),
        .level  (ad_level),
        .rd_val (ad_rd)
    );

    // Port R input synchronisers and read select
    arpg_sync_sel #(
        .W      (8)
    ) u_r_sync (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .pin_in (r_pin_in),
        .in_en  (8'hFF),
        .dir    (port_r_direction_r),
        .data   (port_r_pin_data_r),
        .level  (r_pin_level),
        .rd_val (r_rd)
    );

    // CAN receive comes from the synced pin level
    assign can_receive_pin = r_pin_level[0];

    // Capture write address and data independently
    always @(posedge clk) begin
        if (rst) begin
            aw_idx_r  <= 10'h000;
            aw_full_r <= 1'b0;
            w_byte_r  <= `ARPG_RST_8;
            w_lane_r  <= 1'b0;
            w_full_r  <= 1'b0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_idx_r  <= s_axi_awaddr[11:2];
                aw_full_r <= 1'b1;
            end else if (do_write) begin
                aw_full_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_byte_r <= s_axi_wdata[7:0];
                w_lane_r <= s_axi_wstrb[0];
                w_full_r <= 1'b1;
            end else if (do_write) begin
                w_full_r <= 1'b0;
            end
        end
    end

    // Register file writes; reset leaves every pin an input
    always @(posedge clk) begin
        if (rst) begin
            analog_port_direction_high_r   <= `ARPG_RST_8;
            analog_port_data_high_r        <= `ARPG_RST_8;
            analog_port_pull_enable_low_r  <= `ARPG_RST_4;
            analog_port_pull_enable_high_r <= `ARPG_RST_8;
            ad_pol_lo_r                    <= `ARPG_RST_4;
            ad_pol_hi_r                    <= `ARPG_RST_8;
            port_r_pin_data_r              <= `ARPG_RST_8;
            port_r_direction_r             <= `ARPG_RST_8;
        end else if (do_write && w_lane_r && aw_in_range) begin
            case (aw_idx_r)
                `ARPG_IDX_AD_DIR: begin
                    analog_port_direction_high_r <= w_byte_r;
                end
                `ARPG_IDX_AD_DATA: begin
                    analog_port_data_high_r <= w_byte_r;
                end
                `ARPG_IDX_AD_PE_LO: begin
                    analog_port_pull_enable_low_r <= w_byte_r[3:0];
                end
                `ARPG_IDX_AD_PE_HI: begin
                    analog_port_pull_enable_high_r <= w_byte_r;
                end
                `ARPG_IDX_AD_PS_LO: begin
                    ad_pol_lo_r <= w_byte_r[3:0];
                end
                `ARPG_IDX_AD_PS_HI: begin
                    ad_pol_hi_r <= w_byte_r;
                end
                `ARPG_IDX_R_DATA: begin
                    port_r_pin_data_r <= w_byte_r;
                end
                `ARPG_IDX_R_DIR: begin
                    port_r_direction_r <= w_byte_r;
                end
                // Reserved holes swallow the write
                default: begin
                    port_r_direction_r <= port_r_direction_r;
                end
            endcase
        end
    end

    // Write response: okay inside the block, decode error outside
    always @(posedge clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `ARPG_RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= aw_in_range ? `ARPG_RESP_OKAY
                                            : `ARPG_RESP_DECERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read byte select; holes and upper bits read zero
    always @* begin
        rd_byte = 8'h00;
        case (ar_idx)
            `ARPG_IDX_AD_DATA:  rd_byte = ad_rd;
            `ARPG_IDX_AD_DIR:   rd_byte = analog_port_direction_high_r;
            `ARPG_IDX_AD_PE_LO: rd_byte = {4'h0,
                                           analog_port_pull_enable_low_r};
            `ARPG_IDX_AD_PE_HI: rd_byte = analog_port_pull_enable_high_r;
            `ARPG_IDX_AD_PS_LO: rd_byte = {4'h0, ad_pol_lo_r};
            `ARPG_IDX_AD_PS_HI: rd_byte = ad_pol_hi_r;
            `ARPG_IDX_R_DATA:   rd_byte = r_rd;
            `ARPG_IDX_R_DIR:    rd_byte = port_r_direction_r;
            default:            rd_byte = 8'h00;
        endcase
    end

    // Read data channel, answer one cycle after the address
    always @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `ARPG_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= ar_in_range ? {24'h00_0000, rd_byte}
                                            : 32'h0000_0000;
                s_axi_rresp  <= ar_in_range ? `ARPG_RESP_OKAY
                                            : `ARPG_RESP_DECERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Analog pins: drive, direction and pull devices
    always @(posedge clk) begin
        if (rst) begin
            ad_hi_pin_out <= `ARPG_RST_8;
            ad_hi_pin_oe  <= `ARPG_RST_8;
            ad_hi_pull_en <= `ARPG_RST_8;
            ad_hi_pull_up <= `ARPG_RST_8;
            ad_lo_pull_en <= `ARPG_RST_4;
            ad_lo_pull_up <= `ARPG_RST_4;
        end else if (ce) begin
            ad_hi_pin_out <= analog_port_data_high_r;
            ad_hi_pin_oe  <= analog_port_direction_high_r;
            // Pull only on pins that are inputs
            ad_hi_pull_en <= analog_port_pull_enable_high_r &
                             ~analog_port_direction_high_r;
            ad_lo_pull_en <= analog_port_pull_enable_low_r &
                             ~ad_lo_dir;
            // Polarity bit low selects pull-up
            ad_hi_pull_up <= ~ad_pol_hi_r;
            ad_lo_pull_up <= ~ad_pol_lo_r;
        end
    end

    // Port R routing: per pin owner by priority
    reg [7:0] r_out_nxt;    // Next pin output level
    reg [7:0] r_oe_nxt;     // Next pin output enable
    reg [3:0] r_lcd_nxt;    // Next LCD segment select

    always @* begin
        // GPIO default on every pin
        r_out_nxt = port_r_pin_data_r;
        r_oe_nxt  = port_r_direction_r;
        r_lcd_nxt = lcd_seg_en;
        // Pins 7 and 4: LCD segment turns off the output driver
        if (lcd_seg_en[3]) begin
            r_oe_nxt[7] = 1'b0;
        end
        if (lcd_seg_en[0]) begin
            r_oe_nxt[4] = 1'b0;
        end
        // Pin 6: LCD, else I2C clock open drain, else GPIO
        if (lcd_seg_en[2]) begin
            r_oe_nxt[6] = 1'b0;
        end else if (i2c_en) begin
            r_out_nxt[6] = 1'b0;
            r_oe_nxt[6]  = i2c_scl_drive_low;
        end
        // Pin 5: LCD, else I2C data open drain, else GPIO
        if (lcd_seg_en[1]) begin
            r_oe_nxt[5] = 1'b0;
        end else if (i2c_en) begin
            r_out_nxt[5] = 1'b0;
            r_oe_nxt[5]  = i2c_sda_drive_low;
        end
        // Pins 3 and 2: second timer compare over GPIO
        if (tmr_b_oc_en[1]) begin
            r_out_nxt[3] = tmr_b_oc_out[1];
            r_oe_nxt[3]  = 1'b1;
        end
        if (tmr_b_oc_en[0]) begin
            r_out_nxt[2] = tmr_b_oc_out[0];
            r_oe_nxt[2]  = 1'b1;
        end
        // Pin 1: CAN transmit, else first timer compare, else GPIO
        if (can_en) begin
            r_out_nxt[1] = can_transmit_pin;
            r_oe_nxt[1]  = 1'b1;
        end else if (tmr_a_oc_en[1]) begin
            r_out_nxt[1] = tmr_a_oc_out[1];
            r_oe_nxt[1]  = 1'b1;
        end
        // Pin 0: CAN receive input, else timer compare, else GPIO
        if (can_en) begin
            r_out_nxt[0] = 1'b0;
            r_oe_nxt[0]  = 1'b0;
        end else if (tmr_a_oc_en[0]) begin
            r_out_nxt[0] = tmr_a_oc_out[0];
            r_oe_nxt[0]  = 1'b1;
        end
    end

    // Port R pin drivers registered
    always @(posedge clk) begin
        if (rst) begin
            r_pin_out <= `ARPG_RST_8;
            r_pin_oe  <= `ARPG_RST_8;
            r_lcd_sel <= `ARPG_RST_4;
        end else if (ce) begin
            r_pin_out <= r_out_nxt;
            r_pin_oe  <= r_oe_nxt;
            r_lcd_sel <= r_lcd_nxt;
        end
    end

endmodule // arpg_top

// ---- sim/arpg_pad_model.sv ----
/*
 * Pad model for one port: block driver, bench driver, pull, float.
 * Assumes the bench never drives a pin while the block drives it.
 */
`timescale 1ns/100ps
module arpg_pad_model #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire [W-1:0] out,
    input  wire [W-1:0] oe,
    input  wire [W-1:0] pull_en,
    input  wire [W-1:0] pull_up,
    input  wire [W-1:0] ext_en,
    input  wire [W-1:0] ext_val,
    output wire [W-1:0] level
);
    // Undriven, unpulled pins wander so a lost pull shows
    reg [W-1:0] flt_r = {W{1'h0}};
    always @(posedge clk) begin
        flt_r <= ~flt_r;
    end
    // Block first, then bench, then pull device, else float
    assign level = oe & out | ~oe & (ext_en & ext_val
        | ~ext_en & (pull_en & pull_up | ~pull_en & flt_r));
endmodule // arpg_pad_model

// ---- sim/arpg_top_asserts.sv ----
/*
 * Port-level checker for the port controller, bound into arpg_top.
 * Assumes one clock domain and synchronous active-high reset.
 */
`timescale 1ns/100ps
module arpg_top_asserts (
    input wire        clk,
    input wire        rst,
    input wire        ce,
    input wire [11:0] s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire [7:0]  ad_hi_pin_oe,
    input wire [7:0]  ad_hi_pull_en,
    input wire [3:0]  ad_lo_dir,
    input wire [3:0]  ad_lo_pull_en,
    input wire [7:0]  r_pin_out,
    input wire [7:0]  r_pin_oe,
    input wire [7:0]  r_pin_level,
    input wire [3:0]  lcd_seg_en,
    input wire        i2c_en,
    input wire        i2c_scl_drive_low,
    input wire [1:0]  tmr_b_oc_en,
    input wire [1:0]  tmr_b_oc_out,
    input wire [1:0]  tmr_a_oc_en,
    input wire [1:0]  tmr_a_oc_out,
    input wire        can_en,
    input wire        can_transmit_pin,
    input wire        can_receive_pin,
    input wire [3:0]  r_lcd_sel
);
    reg  ce_q;                 // Clock enable one cycle back
    reg  rst_q;                // Reset one cycle back
    wire live = ce_q & ~rst_q; // Previous edge updated outputs
    // Previous-cycle run state
    always @(posedge clk) begin
        ce_q  <= ce;
        rst_q <= rst;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_reset_clear: assert property ($fell(rst) |-> ad_hi_pin_oe == 8'h00
        && r_pin_oe == 8'h00 && ad_hi_pull_en == 8'h00)
        else $error("pins not idle after reset");
    a_out_no_pull: assert property ((ad_hi_pull_en & ad_hi_pin_oe) == 8'h00)
        else $error("pull active on output pin");
    a_lo_out_nopull: assert property (live |->
        (ad_lo_pull_en & $past(ad_lo_dir)) == 4'h0)
        else $error("low pull active on output pin");
    a_lcd_sel_lag: assert property (live |-> r_lcd_sel == $past(lcd_seg_en))
        else $error("segment select wrong");
    a_lcd_pins_off: assert property ((r_pin_oe[7:4] & r_lcd_sel) == 4'h0)
        else $error("segment pin still driven");
    a_i2c_scl_own: assert property (live && $past(i2c_en)
        && !$past(lcd_seg_en[2]) |-> r_pin_oe[6] == $past(i2c_scl_drive_low)
        && !r_pin_out[6]) else $error("clock pin not owned by serial bus");
    a_tmr_b_cmp: assert property (live && $past(tmr_b_oc_en[1]) |->
        r_pin_oe[3] && r_pin_out[3] == $past(tmr_b_oc_out[1]))
        else $error("compare output missing on pin 3");
    a_can_tx_rx: assert property (live && $past(can_en) |-> r_pin_oe[1]
        && r_pin_out[1] == $past(can_transmit_pin) && !r_pin_oe[0])
        else $error("transmit or receive pin wrong");
    a_tmr_a_cmp: assert property (live && !$past(can_en)
        && $past(tmr_a_oc_en[0]) |-> r_pin_oe[0]
        && r_pin_out[0] == $past(tmr_a_oc_out[0]))
        else $error("compare output missing on pin 0");
    a_can_rx_level: assert property (can_receive_pin == r_pin_level[0])
        else $error("receive line not the pin level");
    a_rsvd_read_zero: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[11:2] == 10'h274 |=> s_axi_rvalid
        && s_axi_rdata == 32'h0 && s_axi_rresp == 2'h0)
        else $error("reserved read not zero");
    // Main scenarios reached
    c_can: cover property (live && $past(can_en));
    c_lcd: cover property (r_lcd_sel != 4'h0);
    c_rd: cover property (s_axi_rvalid);
endmodule // arpg_top_asserts

bind arpg_top arpg_top_asserts u_chk (.*);

// ---- sim/testbench.sv ----
/*
 * Self-checking bench for arpg_top: register bus master, pad models.
 * Assumes 100 ns clock, synchronous reset held for 8 cycles.
 */
`timescale 1ns/100ps
module testbench;
    logic clk, rst, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, i2c_en, i2c_scl_drive_low;
    logic i2c_sda_drive_low, can_en, can_transmit_pin;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb, ad_lo_dir, lcd_seg_en;
    logic [1:0]  tmr_b_oc_en, tmr_b_oc_out, tmr_a_oc_en, tmr_a_oc_out;
    logic [7:0]  converter_digital_input_enable, ad_xe, ad_xv, r_xe, r_xv;
    wire  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire  s_axi_rvalid, can_receive_pin;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0]  ad_hi_pin_in, ad_hi_pin_out, ad_hi_pin_oe, ad_hi_pull_en;
    wire [7:0]  ad_hi_pull_up, r_pin_in, r_pin_out, r_pin_oe, r_pin_level;
    wire [3:0]  ad_lo_pull_en, ad_lo_pull_up, r_lcd_sel;
    logic [1:0] last_resp;   // Response of the latest bus transfer
    int n_mismatch, check_count;

    arpg_top u_dut (.*);
    // Analog port pads
    arpg_pad_model #(.W(8)) u_ad_pad (.clk(clk), .out(ad_hi_pin_out),
        .oe(ad_hi_pin_oe), .pull_en(ad_hi_pull_en), .pull_up(ad_hi_pull_up),
        .ext_en(ad_xe), .ext_val(ad_xv), .level(ad_hi_pin_in));
    // Port R pads; serial bus lines carry pull-ups
    arpg_pad_model #(.W(8)) u_r_pad (.clk(clk), .out(r_pin_out),
        .oe(r_pin_oe), .pull_en(8'h60), .pull_up(8'hFF),
        .ext_en(r_xe), .ext_val(r_xv), .level(r_pin_in));

    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Settle: n rising edges, then sample at the falling edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // One register write; address and data offered together
    task automatic wr(input [9:0] idx, input [7:0] d);
        int n;
        @(posedge clk);
        s_axi_awaddr  <= {idx, 2'h0};
        s_axi_wdata   <= {24'h00_0000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        last_resp = s_axi_bresp;
        if (n == 50) n_mismatch++;
    endtask

    // One register read, compared with the expected word
    task automatic rdc(input [9:0] idx, input [31:0] want);
        int n;
        @(posedge clk);
        s_axi_araddr  <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        last_resp = s_axi_rresp;
        if (n == 50) n_mismatch++;
        chk(s_axi_rdata, want);
    endtask

    // Port R peripheral requests, then pin drive check
    task automatic rmode(input [3:0] lcd, input [2:0] iic, input [7:0] tim,
                         input [1:0] cn, input [7:0] eoe, input [7:0] eout);
        @(posedge clk);
        lcd_seg_en <= lcd;
        {i2c_en, i2c_scl_drive_low, i2c_sda_drive_low} <= iic;
        {tmr_b_oc_en, tmr_b_oc_out, tmr_a_oc_en, tmr_a_oc_out} <= tim;
        {can_en, can_transmit_pin} <= cn;
        tick(2);
        chk(r_pin_oe, eoe);
        chk(r_pin_out & eoe, eout);
        chk(r_lcd_sel, lcd);
    endtask

    task automatic t_reset;
        logic [9:0] idx [8] = '{10'h271, 10'h273, 10'h276, 10'h277,
                                10'h278, 10'h279, 10'h280, 10'h282};
        foreach (idx[i]) rdc(idx[i], 32'h0);
        chk({ad_hi_pin_oe, r_pin_oe, ad_hi_pull_en}, 32'h0);
        chk({ad_lo_pull_en, r_lcd_sel}, 32'h0);
        @(posedge clk);
        converter_digital_input_enable <= 8'hFF;
        r_xe <= 8'h00;
        $display("t_reset done");
    endtask

    task automatic t_ad_gpio;
        wr(10'h271, 8'hA5);
        wr(10'h273, 8'hFF);
        tick(1);
        chk(ad_hi_pin_oe, 8'hFF);
        chk(ad_hi_pin_out, 8'hA5);
        rdc(10'h271, 32'hA5);
        @(posedge clk);
        ad_xe <= 8'hFF;
        ad_xv <= 8'hC3;
        wr(10'h273, 8'h00);
        tick(3);
        rdc(10'h271, 32'hC3);
        @(posedge clk);
        ad_xe <= 8'hF0;
        ad_xv <= 8'h30;
        wr(10'h273, 8'h0F);
        tick(3);
        chk(ad_hi_pin_oe, 8'h0F);
        rdc(10'h271, 32'h35);
        @(posedge clk);
        converter_digital_input_enable <= 8'hEF;
        tick(3);
        rdc(10'h271, 32'h25);
        @(posedge clk);
        converter_digital_input_enable <= 8'hFF;
        ad_xe <= 8'h00;
        $display("t_ad_gpio done");
    endtask

    task automatic t_pull;
        wr(10'h277, 8'hFF);
        wr(10'h279, 8'hC0);
        wr(10'h276, 8'h0F);
        wr(10'h278, 8'h05);
        tick(1);
        chk(ad_hi_pull_en, 8'hF0);
        chk(ad_hi_pull_up, 8'h3F);
        chk(ad_lo_pull_en, 4'hC);
        chk(ad_lo_pull_up, 4'hA);
        rdc(10'h276, 32'h0F);
        tick(2);
        rdc(10'h271, 32'h35);
        wr(10'h277, 8'h00);
        tick(1);
        chk(ad_hi_pull_en, 8'h00);
        $display("t_pull done");
    endtask

    task automatic t_port_r;
        wr(10'h282, 8'hFF);
        wr(10'h280, 8'hD6);
        rmode(4'h0, 3'h0, 8'h00, 2'h0, 8'hFF, 8'hD6);
        rmode(4'hF, 3'h7, 8'h00, 2'h0, 8'h0F, 8'h06);
        rmode(4'h0, 3'h6, 8'h00, 2'h0, 8'hDF, 8'h96);
        rmode(4'h0, 3'h0, 8'hE0, 2'h0, 8'hFF, 8'hDA);
        rmode(4'h0, 3'h0, 8'h0D, 2'h0, 8'hFF, 8'hD5);
        rmode(4'h0, 3'h0, 8'h0F, 2'h2, 8'hFE, 8'hD4);
        @(posedge clk);
        r_xe <= 8'h01;
        r_xv <= 8'h01;
        tick(3);
        chk(can_receive_pin, 1'h1);
        @(posedge clk);
        r_xe <= 8'h00;
        rmode(4'h4, 3'h5, 8'h00, 2'h0, 8'hBF, 8'h96);
        rmode(4'h0, 3'h0, 8'h00, 2'h0, 8'hFF, 8'hD6);
        wr(10'h282, 8'hF0);
        @(posedge clk);
        r_xe <= 8'h0F;
        r_xv <= 8'h0A;
        tick(3);
        rdc(10'h280, 32'hDA);
        $display("t_port_r done");
    endtask

    task automatic t_rsvd;
        wr(10'h274, 8'hFF);
        chk(last_resp, 2'h0);
        rdc(10'h274, 32'h0);
        chk(last_resp, 2'h0);
        rdc(10'h28F, 32'h0);
        s_axi_wstrb <= 4'hE;
        wr(10'h277, 8'h5A);
        rdc(10'h277, 32'h0);
        rdc(10'h100, 32'h0);
        chk(last_resp, 2'h3);
        $display("t_rsvd done");
    endtask

    // Watchdog cuts a hang short
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        final_report;
    end

    initial begin
        {rst, ce} = 2'h3;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, i2c_en, i2c_scl_drive_low} = 4'h0;
        {i2c_sda_drive_low, can_en, can_transmit_pin} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        {s_axi_wstrb, ad_lo_dir, lcd_seg_en} = 12'hF30;
        {tmr_b_oc_en, tmr_b_oc_out, tmr_a_oc_en, tmr_a_oc_out} = 8'h00;
        {converter_digital_input_enable, ad_xe, ad_xv} = 24'h00_FF00;
        {r_xe, r_xv} = 16'hFF00;
        n_mismatch = 0;
        check_count = 0;
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        t_reset;
        t_ad_gpio;
        t_pull;
        t_port_r;
        t_rsvd;
        final_report;
    end
endmodule // testbench
